/* rtl/buck_gate_sequencer.sv */
// power-up detection, soft start, gate sequencing and protection
// assumes analog comparators drive the sense inputs asynchronously
`timescale 1ns/100ps
`default_nettype none

module buck_gate_sequencer
   import buck_seq_pkg::*;
#(
   parameter int DET_PERIOD_CYCLES  = DET_PERIOD_CYC,
   parameter int SS_CYCLES          = SS_CYC,
   parameter int HICCUP_CYCLES      = HICCUP_CYC,
   parameter int START_DELAY_CYCLES = START_DELAY_CYC,
   parameter int SS_W               = SS_CODE_W
) (
   input  wire logic            sys_clk,
   input  wire logic            sys_rst,
   input  wire logic            phase_above_detect,
   input  wire logic            phase_below_oc,
   input  wire logic            feedback_at_ref,
   input  wire logic            feedback_below_uv,
   input  wire logic            over_temp_alarm,
   input  wire logic            duty_end_req,
   output var  logic            high_side_gate_drive,
   output var  logic            low_side_gate_drive,
   output var  logic [SS_W-1:0] soft_start_ref,
   output var  logic            power_input_ready,
   output var  logic            soft_start_done,
   output var  logic            overcurrent_shutdown,
   output var  logic            undervoltage_shutdown,
   output var  logic            over_temp_shutdown
);
   localparam int SS_RAW  = SS_CYCLES >> SS_W;
   localparam int SS_STEP = (SS_RAW > 0) ? SS_RAW : 1;

   // ------------------------------------------------------------
   // input synchronisers
   // ------------------------------------------------------------
   logic [5:0] sense_s;
   logic       ph_det_s;
   logic       oc_s;
   logic       fb_ref_s;
   logic       fb_uv_s;
   logic       ot_s;
   logic       duty_end_s;

   sense_sync #(.W(6)) u_sync (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .d       ({duty_end_req, over_temp_alarm, feedback_below_uv,
                 feedback_at_ref, phase_below_oc, phase_above_detect}),
      .q       (sense_s)
   );

   assign ph_det_s   = sense_s[0];
   assign oc_s       = sense_s[1];
   assign fb_ref_s   = sense_s[2];
   assign fb_uv_s    = sense_s[3];
   assign ot_s       = sense_s[4];
   assign duty_end_s = sense_s[5];

   // ------------------------------------------------------------
   // switching cycle generator
   // ------------------------------------------------------------
   pwm_link_if pw ();

   logic run_r;
   logic permit_r;

   assign pw.run      = run_r;
   assign pw.permit   = permit_r;
   assign pw.duty_end = duty_end_s;

   switch_cycle_gen u_gen (
      .sys_clk (sys_clk),
      .sys_rst (sys_rst),
      .pw      (pw)
   );

   // ------------------------------------------------------------
   // sequencer state
   // ------------------------------------------------------------
   seq_state_e       state_r;
   logic [TMR_W-1:0] tmr_r;
   logic [1:0]       hiccups_r;
   logic [1:0]       crossings_r;
   logic [2:0]       oc_consec_r;
   logic             oc_seen_r;
   logic [TMR_W-1:0] uv_cnt_r;
   logic             switching;
   logic             oc_trip;
   logic             uv_trip;

   assign switching = state_r == ST_SOFT || state_r == ST_RUN;
   assign oc_trip   = switching && pw.cycle_close && oc_seen_r &&
                      oc_consec_r == 3'(OC_TRIP_COUNT - 1); // see RL11
   assign uv_trip   = state_r == ST_RUN && fb_uv_s &&
                      uv_cnt_r == TMR_W'(UV_CYC - 1); // see RL14

   // only sys_rst leaves the latched state
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_r               <= ST_DETECT;
         tmr_r                 <= '0;
         hiccups_r             <= '0;
         overcurrent_shutdown  <= 1'b0;
         undervoltage_shutdown <= 1'b0;
         over_temp_shutdown    <= 1'b0;
      end else if (ot_s) begin
         // also flags over-temperature when already latched off
         state_r            <= ST_LATCHED; // see RL15
         over_temp_shutdown <= 1'b1;
      end else begin
         case (state_r)
            ST_DETECT: begin
               if (crossings_r == 2'(DET_CROSSINGS)) begin
                  state_r <= ST_DELAY; // see RL3
                  tmr_r   <= '0;
               end
            end
            ST_DELAY: begin
               tmr_r <= tmr_r + 1'b1;
               if (tmr_r == TMR_W'(START_DELAY_CYCLES - 1))
                  state_r <= ST_SOFT; // see RL4, RL16
            end
            ST_SOFT, ST_RUN: begin
               tmr_r <= '0;
               if (oc_trip) begin
                  if (hiccups_r == 2'(HICCUP_LIMIT)) begin
                     state_r              <= ST_LATCHED; // see RL13
                     overcurrent_shutdown <= 1'b1;
                  end else begin
                     state_r   <= ST_HICCUP; // see RL12
                     hiccups_r <= hiccups_r + 1'b1;
                  end
               end else if (uv_trip) begin
                  // undervoltage never counts toward latch-off
                  state_r               <= ST_HICCUP; // see RL14
                  undervoltage_shutdown <= 1'b1;
               end else if (state_r == ST_SOFT && fb_ref_s) begin
                  state_r <= ST_RUN; // see RL5
               end
            end
            ST_HICCUP: begin
               tmr_r <= tmr_r + 1'b1;
               if (tmr_r == TMR_W'(HICCUP_CYCLES - 1)) begin
                  state_r               <= ST_DELAY;
                  tmr_r                 <= '0;
                  undervoltage_shutdown <= 1'b0;
               end
            end
            ST_LATCHED: state_r <= ST_LATCHED; // see RL17
            default:    state_r <= ST_DETECT;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         power_input_ready <= 1'b0;
         soft_start_done   <= 1'b0;
      end else begin
         power_input_ready <= state_r != ST_DETECT;
         soft_start_done   <= state_r == ST_RUN;
      end
   end

   // ------------------------------------------------------------
   // input detection
   // ------------------------------------------------------------
   logic [TMR_W-1:0] det_cnt_r;
   logic             det_pulse_r;
   logic             ph_prev_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst || state_r != ST_DETECT ||
          det_cnt_r == TMR_W'(DET_PERIOD_CYCLES - 1))
         det_cnt_r <= '0;
      else
         det_cnt_r <= det_cnt_r + 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         det_pulse_r <= 1'b0;
      else
         det_pulse_r <= state_r == ST_DETECT &&
                        det_cnt_r < TMR_W'(DET_WIDTH_CYC); // see RL1
   end

   // a crossing counts once the node has risen and fallen back
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         ph_prev_r   <= 1'b0;
         crossings_r <= '0;
      end else begin
         ph_prev_r <= ph_det_s;
         if (state_r == ST_DETECT && ph_prev_r && !ph_det_s &&
             crossings_r != 2'(DET_CROSSINGS))
            crossings_r <= crossings_r + 1'b1; // see RL2
      end
   end

   // ------------------------------------------------------------
   // soft-start ramp
   // ------------------------------------------------------------
   logic [TMR_W-1:0] ss_step_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst || state_r != ST_SOFT ||
          ss_step_r == TMR_W'(SS_STEP - 1))
         ss_step_r <= '0;
      else
         ss_step_r <= ss_step_r + 1'b1;
   end

   // full scale is reached at the nominal interval; done needs feedback
   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         soft_start_ref <= '0;
      else if (state_r == ST_RUN)
         soft_start_ref <= '1;
      else if (state_r != ST_SOFT)
         soft_start_ref <= '0;
      else if (ss_step_r == TMR_W'(SS_STEP - 1) && soft_start_ref != '1)
         soft_start_ref <= soft_start_ref + 1'b1; // see RL5, RL6
   end

   // ------------------------------------------------------------
   // over-current and undervoltage sensing
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         oc_seen_r <= 1'b0;
      else
         oc_seen_r <= (switching && pw.ls_cmd && oc_s) ||
                      (oc_seen_r && !pw.cycle_close); // see RL8
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !switching) begin
         oc_consec_r <= '0;
         permit_r    <= 1'b1;
      end else if (pw.cycle_close) begin
         permit_r <= !oc_seen_r; // see RL9, RL10
         if (oc_seen_r)
            oc_consec_r <= oc_consec_r + 1'b1;
         else
            oc_consec_r <= '0; // see RL11
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || state_r != ST_RUN || !fb_uv_s)
         uv_cnt_r <= '0;
      else if (!uv_trip)
         uv_cnt_r <= uv_cnt_r + 1'b1;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         run_r <= 1'b0;
      else
         run_r <= switching && !oc_trip && !uv_trip && !ot_s;
   end

   // ------------------------------------------------------------
   // gate outputs
   // ------------------------------------------------------------
   // both gates held low outside detection and switching states
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         high_side_gate_drive <= 1'b0;
         low_side_gate_drive  <= 1'b0;
      end else begin
         high_side_gate_drive <= (state_r == ST_DETECT && det_pulse_r) ||
                                 (run_r && switching && pw.hs_cmd);
         low_side_gate_drive  <= run_r && switching && pw.ls_cmd; // see RL12
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   gate_no_overlap_a: assert property ( // see RL7
      !(high_side_gate_drive && low_side_gate_drive))
      else $error("both gates high together");
   detect_pulse_stop_a: assert property ( // see RL3
      power_input_ready |=> !det_pulse_r)
      else $error("detection pulse after input recognised");
   oc_suppress_a: assert property ( // see RL9
      (switching && pw.cycle_close && oc_seen_r) |-> ##2 !pw.hs_cmd)
      else $error("high side not suppressed after event");
   oc_resume_a: assert property ( // see RL10
      (switching && pw.cycle_close && !oc_seen_r) |->
         ##2 (pw.hs_cmd || !run_r))
      else $error("high side not resumed after clean cycle");
   oc_trip_a: assert property ( // see RL11
      oc_trip && !ot_s |=> state_r inside {ST_HICCUP, ST_LATCHED})
      else $error("fourth event did not trip");
   hiccup_gates_low_a: assert property ( // see RL12
      state_r == ST_HICCUP ##1 state_r == ST_HICCUP |->
         !high_side_gate_drive && !low_side_gate_drive)
      else $error("gate high during hiccup");
   oc_latch_off_a: assert property ( // see RL13
      (oc_trip && hiccups_r == 2'(HICCUP_LIMIT) && !ot_s) |=>
         state_r == ST_LATCHED && overcurrent_shutdown)
      else $error("fourth trip did not latch off");
   latch_hold_a: assert property ( // see RL17
      state_r == ST_LATCHED |=> state_r == ST_LATCHED ##1
         !high_side_gate_drive && !low_side_gate_drive)
      else $error("latched state left or gate high");
   uv_trip_a: assert property ( // see RL14
      uv_trip && !ot_s && !oc_trip |=> state_r == ST_HICCUP &&
         undervoltage_shutdown)
      else $error("undervoltage did not start hiccup");
   ot_latch_a: assert property ( // see RL15
      ot_s |=> state_r == ST_LATCHED && over_temp_shutdown)
      else $error("over-temperature not latched");
   ss_monotone_a: assert property ( // see RL5
      state_r == ST_SOFT && $past(state_r) == ST_SOFT |->
         soft_start_ref >= $past(soft_start_ref))
      else $error("soft-start reference fell");

   reach_run_c:    cover property (state_r == ST_SOFT ##1 state_r == ST_RUN);
   hiccup_c:       cover property ($rose(state_r == ST_HICCUP));
   latched_oc_c:   cover property ($rose(overcurrent_shutdown));
   suppressed_c:   cover property ($fell(permit_r) && run_r);
endmodule : buck_gate_sequencer

`default_nettype wire

/* rtl/buck_seq_pkg.sv */
// constants, timing counts and states of the buck gate sequencer
// assumes a 200 MHz system clock that runs from power-on reset
//
// How it works
// RL1: after power-on reset, send narrow high-side pulses at about 6 kHz.
// RL2: count switch node crossings of the detection level during detection.
// RL3: two crossings above and back below stop pulses; input is present.
// RL4: soft start follows a delay; without input, detection pulses go on.
// RL5: soft-start reference ramps up from zero; ends when feedback reaches it.
// RL6: soft start lasts about 3 ms, within 1 ms to 6 ms.
// RL7: low-side gate turns on only after dead time, never overlapping.
// RL8: switch node below -350 mV during low-side conduction is an event.
// RL9: each over-current event drops one high-side pulse; low side keeps going.
// RL10: high-side pulses resume after an event-free cycle.
// RL11: four consecutive events trip shutdown; clean cycle restarts count.
// RL12: on over-current trip both gates go low, then hiccup restart.
// RL13: three hiccup restarts allowed; next trip latches off, gates low.
// RL14: after soft start, feedback low for 10 us forces a hiccup restart.
// RL15: over-temperature turns both gates off and latches.
// RL16: input-recognised to soft-start delay is a parameterised cycle count.
// RL17: only a new power-on reset clears a latched-off state.

package buck_seq_pkg;

   // ------------------------------------------------------------
   // clock
   // ------------------------------------------------------------
   localparam int CLK_FREQ_HZ   = 200_000_000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int CLK_PER_US    = CLK_FREQ_HZ / 1_000_000;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int DET_FREQ_HZ   = 6_000;
   localparam int DET_PERIOD_CYC = CLK_FREQ_HZ / DET_FREQ_HZ;
   localparam int DET_WIDTH_NS  = 200;
   localparam int DET_WIDTH_CYC =
      (DET_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SW_FREQ_HZ    = 400_000;
   localparam int SW_PERIOD_CYC = CLK_FREQ_HZ / SW_FREQ_HZ;
   localparam int MAX_DUTY_PCT  = 80;
   localparam int MAX_ON_CYC    = SW_PERIOD_CYC * MAX_DUTY_PCT / 100;
   localparam int DEAD_TIME_NS  = 20;
   localparam int DEAD_CYC      =
      (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SS_TIME_US    = 3_000;
   localparam int SS_CYC        = SS_TIME_US * CLK_PER_US;
   localparam int UV_DELAY_NS   = 10_000;
   localparam int UV_CYC        =
      (UV_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HICCUP_US     = 2_000;
   localparam int HICCUP_CYC    = HICCUP_US * CLK_PER_US;
   localparam int START_DELAY_CYC = 1_024;

   // ------------------------------------------------------------
   // counts and widths
   // ------------------------------------------------------------
   localparam int DET_CROSSINGS = 2;
   localparam int OC_TRIP_COUNT = 4;
   localparam int HICCUP_LIMIT  = 3;
   localparam int SS_CODE_W     = 10;
   localparam int TMR_W         = 20;

   typedef enum logic [2:0] {
      ST_DETECT,
      ST_DELAY,
      ST_SOFT,
      ST_RUN,
      ST_HICCUP,
      ST_LATCHED
   } seq_state_e;

endpackage : buck_seq_pkg

/* rtl/pwm_link_if.sv */
// control link between the sequencer and the switching cycle generator
// assumes both ends sit on sys_clk
`timescale 1ns/100ps
`default_nettype none

interface pwm_link_if;
   logic run;
   logic permit;
   logic duty_end;
   logic cycle_close;
   logic hs_cmd;
   logic ls_cmd;

   modport ctl (output run, output permit, output duty_end,
                input cycle_close, input hs_cmd, input ls_cmd);
   modport gen (input run, input permit, input duty_end,
                output cycle_close, output hs_cmd, output ls_cmd);
endinterface : pwm_link_if

`default_nettype wire

/* rtl/sense_sync.sv */
// two-flop synchroniser for comparator and pin inputs
// assumes inputs are asynchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none

module sense_sync #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule : sense_sync

`default_nettype wire

/* rtl/switch_cycle_gen.sv */
// fixed-frequency switching cycle with max duty and dead time
// assumes run, permit and duty_end come from logic on sys_clk
`timescale 1ns/100ps
`default_nettype none

module switch_cycle_gen
   import buck_seq_pkg::*;
#(
   parameter int PERIOD = SW_PERIOD_CYC,
   parameter int MAX_ON = MAX_ON_CYC,
   parameter int DEAD   = DEAD_CYC
) (
   input  wire logic sys_clk,
   input  wire logic sys_rst,
   pwm_link_if.gen   pw
);
   localparam int CW = $clog2(PERIOD);

   logic [CW-1:0] cnt_r;
   logic [CW-1:0] dead_r;
   logic          hs_r;
   logic          ls_r;
   logic          close_r;

   assign pw.hs_cmd      = hs_r;
   assign pw.ls_cmd      = ls_r;
   assign pw.cycle_close = close_r;

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !pw.run || cnt_r == CW'(PERIOD - 1))
         cnt_r <= '0;
      else
         cnt_r <= cnt_r + 1'b1;
   end

   // close lands one cycle before the next high-side decision
   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         close_r <= 1'b0;
      else
         close_r <= pw.run && cnt_r == CW'(PERIOD - 3);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || !pw.run)
         hs_r <= 1'b0;
      else if (cnt_r == CW'(PERIOD - 1))
         hs_r <= pw.permit; // see RL9
      else if (hs_r && (pw.duty_end || cnt_r >= CW'(MAX_ON - 1)))
         hs_r <= 1'b0;
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst || hs_r)
         dead_r <= '0;
      else if (dead_r != CW'(DEAD))
         dead_r <= dead_r + 1'b1;
   end

   // low side keeps switching even when a high-side pulse is dropped
   always_ff @(posedge sys_clk) begin
      if (sys_rst)
         ls_r <= 1'b0;
      else
         ls_r <= pw.run && !hs_r && dead_r == CW'(DEAD) &&
                 cnt_r < CW'(PERIOD - 1 - DEAD); // see RL7
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);

   hs_ls_gap_a: assert property ( // see RL7
      $fell(hs_r) |-> !ls_r [*4])
      else $error("low side rose inside dead time");
   ls_hs_gap_a: assert property ( // see RL7
      $fell(ls_r) |-> !hs_r [*4])
      else $error("high side rose inside dead time");
endmodule : switch_cycle_gen

`default_nettype wire

/* sim/buck_gate_sequencer_test.sv */
// self-checking bench for the buck gate sequencer and power stage model
// assumes the package, link interface and design files compile first
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
   bad_count++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end

module buck_gate_sequencer_test;
   import buck_seq_pkg::*;
   localparam int SSC = 2048;
   localparam int HC  = 100;
   localparam int SD  = 20;
   logic                 sys_clk = 1'b0;
   logic                 sys_rst = 1'b1;
   logic                 above;
   logic                 below;
   logic                 fb_ref = 1'b0;
   logic                 fb_uv = 1'b0;
   logic                 ot = 1'b0;
   logic                 duty_end = 1'b0;
   logic                 vin_on = 1'b0;
   logic                 oc_load = 1'b0;
   logic                 hs, ls, ready, done, oc_off, uv_off, ot_off;
   logic                 hs_q, ls_q, ev, prev_ev, hs_seen, ss_watch;
   logic [SS_CODE_W-1:0] ss_ref, ref_q;
   int bad_count = 0;
   int checks_done = 0;
   int hs_low, hs_rises, hs_high, gate_hi, ls_falls, armed, consec;
   int trips_exp = 0;
   int on_cnt, ton;

   always #2.5 sys_clk = ~sys_clk;

   buck_gate_sequencer #(.DET_PERIOD_CYCLES(200), .SS_CYCLES(SSC),
      .HICCUP_CYCLES(HC), .START_DELAY_CYCLES(SD)) buck_gate_sequencer_i (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .phase_above_detect(above),
      .phase_below_oc(below), .feedback_at_ref(fb_ref),
      .feedback_below_uv(fb_uv), .over_temp_alarm(ot),
      .duty_end_req(duty_end), .high_side_gate_drive(hs),
      .low_side_gate_drive(ls), .soft_start_ref(ss_ref),
      .power_input_ready(ready), .soft_start_done(done),
      .overcurrent_shutdown(oc_off), .undervoltage_shutdown(uv_off),
      .over_temp_shutdown(ot_off));

   power_stage_model power_stage_model_i (.sys_clk(sys_clk), .hs_on(hs),
      .ls_on(ls), .vin_on(vin_on), .oc_load(oc_load),
      .phase_above(above), .phase_below(below));

   // ------------------------------------------------------------
   // reference model and monitors
   // ------------------------------------------------------------
   always @(posedge sys_clk) begin
      if (!sys_rst) begin
         `CHK(hs & ls, 1'b0)
         if (ls & !ls_q) `CHK(hs_low >= DEAD_CYC, 1'b1)
         if (ss_watch) `CHK(ss_ref >= ref_q, 1'b1)
         if (hs & !hs_q) hs_rises++;
         if (hs) hs_high++;
         if (hs | ls) gate_hi++;
         if (ls & oc_load) ev = 1'b1;
         if (hs) hs_seen = 1'b1;
         if (ls_q & !ls) begin
            ls_falls++;
            if (!done) begin
               armed = 0;
               consec = 0;
            end else begin
               if (armed > 0) `CHK(hs_seen, !prev_ev)
               consec = ev ? consec + 1 : 0;
               if (consec == OC_TRIP_COUNT) trips_exp++;
               armed++;
               prev_ev = ev;
            end
            ev = 1'b0;
            hs_seen = 1'b0;
         end
      end
      hs_low = hs ? 0 : hs_low + 1;
      hs_q = hs;
      ls_q = ls;
      ref_q = ss_ref;
   end

   // random on-time so high-side pulses vary in width
   initial begin
      void'($urandom(32'h8ABBCEC3));
      forever begin
         @(posedge sys_clk);
         on_cnt = hs ? on_cnt + 1 : 0;
         if (!hs) ton = 10 + $urandom % 200;
         #1 duty_end = hs && on_cnt >= ton;
      end
   end

   task automatic wrap_up;
      if (bad_count == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : wrap_up

   task automatic step(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : step

   task automatic ran_out;
      bad_count++;
      $display("[ERR] %0t wait ran out", $time);
      wrap_up();
   endtask : ran_out

   task automatic wait_until(input int s, input int lim);
      int n;
      n = 0;
      while ((s ? done : ready) !== 1'b1) begin
         step(1);
         n++;
         if (n > lim) ran_out();
      end
   endtask : wait_until

   task automatic wait_falls(input int k);
      int tgt;
      tgt = ls_falls + k;
      for (int n = 0; ls_falls < tgt; n++) begin
         step(1);
         if (n > 600 * k) ran_out();
      end
   endtask : wait_falls

   // start on a cycle boundary so every low-side window is whole
   task automatic oc_burst(input int k);
      wait_falls(1);
      oc_load = 1'b1;
      wait_falls(k);
      oc_load = 1'b0;
   endtask : oc_burst

   task automatic gates_low_for(input int n);
      step(5);
      gate_hi = 0;
      step(n);
      `CHK(gate_hi, 0)
   endtask : gates_low_for

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      step(4);
      sys_rst = 1'b0;
      hs_rises = 0;
      hs_high = 0;
      step(600);
      `CHK(hs_rises, 3)
      `CHK(hs_high, 3 * DET_WIDTH_CYC)
      `CHK(ready, 1'b0)
      vin_on = 1'b1;
      step(150);
      `CHK(ready, 1'b0)
      wait_until(0, 300);
      hs_rises = 0;
      step(SD - 4);
      `CHK(hs_rises, 0)
      `CHK(ss_ref, 0)
      ss_watch = 1'b1;
      step(SSC / 2);
      `CHK(ss_ref != 0 && ss_ref != '1, 1'b1)
      step(SSC);
      `CHK(done, 1'b0)
      `CHK(ss_ref, {SS_CODE_W{1'b1}})
      ss_watch = 1'b0;
      fb_ref = 1'b1;
      wait_until(1, 20);
      step(2000);
      oc_burst(1);
      step(1500);
      oc_burst(3);
      wait_falls(1);
      oc_burst(3);
      step(1500);
      `CHK(done, 1'b1)
      for (int k = 1; k <= HICCUP_LIMIT; k++) begin
         oc_burst(OC_TRIP_COUNT);
         gates_low_for(80);
         `CHK(trips_exp, k)
         `CHK(oc_off, 1'b0)
         wait_until(1, HC + SD + 200);
         step(1500);
      end
      fb_uv = 1'b1;
      step(UV_CYC - 10);
      `CHK(uv_off, 1'b0)
      step(20);
      `CHK(uv_off, 1'b1)
      fb_uv = 1'b0;
      gates_low_for(50);
      wait_until(1, HC + SD + 200);
      step(1500);
      oc_burst(OC_TRIP_COUNT);
      gates_low_for(300);
      `CHK(oc_off, 1'b1)
      `CHK(trips_exp, HICCUP_LIMIT + 1)
      sys_rst = 1'b1;
      step(4);
      `CHK(oc_off, 1'b0)
      sys_rst = 1'b0;
      wait_until(1, 1500);
      ot = 1'b1;
      step(5);
      ot = 1'b0;
      gates_low_for(300);
      `CHK(ot_off, 1'b1)
      `CHK(done, 1'b0)
      wrap_up();
   end
endmodule : buck_gate_sequencer_test

`undef CHK
`default_nettype wire

/* sim/power_stage_model.sv */
// behavioural half-bridge and switch node comparators for the sequencer
// assumes gate commands come from logic on sys_clk
`timescale 1ns/100ps
`default_nettype none

module power_stage_model (
   input  wire logic sys_clk,
   input  wire logic hs_on,
   input  wire logic ls_on,
   input  wire logic vin_on,
   input  wire logic oc_load,
   output var  logic phase_above,
   output var  logic phase_below
);
   // ------------------------------------------------------------
   // switch node
   // ------------------------------------------------------------
   // node lags the gate by one clock, like a real stage
   // unknown only until the gates leave reset; the sequencer's
   // synchronisers are held in reset over that window
   always @(posedge sys_clk) begin
      phase_above <= vin_on & hs_on;
      phase_below <= oc_load & ls_on;
   end
endmodule : power_stage_model

`default_nettype wire
